// ---- rtl/atc_pkg.sv ----
package atc_pkg;

    // ****************************************************************
    // Identity and budget
    // ****************************************************************
    localparam int          ID_W          = 16;
    localparam int          HIST_DEPTH    = 9;
    localparam int          BUDGET_W      = 4;
    localparam logic [3:0]  BUDGET_RESET  = 4'h8;
    localparam logic [3:0]  BUDGET_STEP   = 4'h1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint      CLK_HZ        = 100000000;
    localparam longint      TEACH_MS      = 20000;
    localparam longint      COMMIT_MS     = 120000;
    localparam longint      NORM_ON_MS    = 500;
    localparam longint      NORM_PER_MS   = 1000;
    localparam longint      QUICK_ON_MS   = 50;
    localparam longint      QUICK_PER_MS  = 1000;
    localparam longint      CYC_PER_MS    = CLK_HZ / 1000;
    localparam longint      TEACH_CYC     = TEACH_MS * CYC_PER_MS;
    localparam longint      COMMIT_CYC    = COMMIT_MS * CYC_PER_MS;
    localparam longint      NORM_ON_CYC   = NORM_ON_MS * CYC_PER_MS;
    localparam longint      NORM_PER_CYC  = NORM_PER_MS * CYC_PER_MS;
    localparam longint      QUICK_ON_CYC  = QUICK_ON_MS * CYC_PER_MS;
    localparam longint      QUICK_PER_CYC = QUICK_PER_MS * CYC_PER_MS;
    localparam int          TMR_W         = 34;

    // ****************************************************************
    // Teach states and indicator patterns
    // ****************************************************************
    typedef enum logic [2:0] {
        ATC_IDLE,
        ATC_LEARN,
        ATC_READY,
        ATC_EXPIRED
    } atc_state_t;

    typedef enum logic [1:0] {
        ATC_IND_STEADY,
        ATC_IND_NORMAL,
        ATC_IND_QUICK
    } atc_ind_t;

endpackage

// ---- rtl/atc_blinker.sv ----
`timescale 1ns/1ps
module atc_blinker
#(
    parameter longint NORM_ON   = atc_pkg::NORM_ON_CYC,
    parameter longint NORM_PER  = atc_pkg::NORM_PER_CYC,
    parameter longint QUICK_ON  = atc_pkg::QUICK_ON_CYC,
    parameter longint QUICK_PER = atc_pkg::QUICK_PER_CYC
)
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire atc_pkg::atc_ind_t mode,
    input  wire logic             steady_on,
    output logic                  lamp
);
    import atc_pkg::*;

    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;
    logic             lamp_r;
    logic             lamp_nxt;
    atc_ind_t         mode_r;
    logic [TMR_W-1:0] per;
    logic [TMR_W-1:0] on_t;

    assign lamp = lamp_r;

    // ****************************************************************
    // Phase counter restarts whenever the pattern changes.
    // ****************************************************************
    always_comb
    begin
        per  = (mode == ATC_IND_QUICK) ? TMR_W'(QUICK_PER) : TMR_W'(NORM_PER);
        on_t = (mode == ATC_IND_QUICK) ? TMR_W'(QUICK_ON) : TMR_W'(NORM_ON);
        if (mode != mode_r || cnt_r >= per - TMR_W'(1))
        begin
            cnt_nxt = '0;
        end
        else
        begin
            cnt_nxt = cnt_r + TMR_W'(1);
        end
        if (mode == ATC_IND_STEADY)
        begin
            lamp_nxt = steady_on;
        end
        else
        begin
            lamp_nxt = (cnt_nxt < on_t);
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cnt_r  <= '0;
            lamp_r <= 1'b0;
            mode_r <= ATC_IND_STEADY;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            lamp_r <= lamp_nxt;
            mode_r <= mode;
        end
    end

endmodule

// ---- rtl/atc_switch.sv ----
// Operation
// - With nothing paired, the first actuator detected is paired automatically.
// - At most eight relearns; further learning is refused once budget is spent.
// - Detecting a relearn candidate starts learning with normal yellow flashing.
// - After twenty seconds held in range, gate indicator flashes quickly.
// - Power cycle within 120 s of quick flash commits; operator performs it.
// - Commit at power-up stores the actuator and decrements the budget by one.
// - An actuator learned before can never be learned again.
// - Chain latency is risk time plus (n-1) input delays plus evaluator delay.
// - All gates closed gives high on both channels at the evaluator.
// - Any single opened gate drives both evaluator channels low.
// - Reclosing the gate restores both channels high with no intervention.
// - Normal flashing is 500 ms on, 500 ms off.
// - Quick flashing is 50 ms on, 950 ms off.
// - Input indicator lit when both chain inputs high, dark when both low.
`timescale 1ns/1ps
module atc_switch
#(
    parameter int     HIST      = atc_pkg::HIST_DEPTH,
    parameter longint TEACH_T   = atc_pkg::TEACH_CYC,
    parameter longint COMMIT_T  = atc_pkg::COMMIT_CYC,
    parameter longint NORM_ON   = atc_pkg::NORM_ON_CYC,
    parameter longint NORM_PER  = atc_pkg::NORM_PER_CYC,
    parameter longint QUICK_ON  = atc_pkg::QUICK_ON_CYC,
    parameter longint QUICK_PER = atc_pkg::QUICK_PER_CYC
)
(
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      tag_present,
    input  wire logic [atc_pkg::ID_W-1:0]  tag_id,
    input  wire logic                      chain_input_ch1,
    input  wire logic                      chain_input_ch2,
    output logic                           safe_out_ch1,
    output logic                           safe_out_ch2,
    output logic                           signal_diag_output,
    output logic                           gate_led,
    output logic                           input_led,
    output logic                           device_led,
    output logic [atc_pkg::BUDGET_W-1:0]   budget_left,
    output logic                           paired_valid
);
    import atc_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0]      s1_r;
    logic [1:0]      s2_r;
    logic [1:0]      sp_r;
    logic [ID_W-1:0] sid1_r;
    logic [ID_W-1:0] sid2_r;
    logic            in1;
    logic            in2;
    logic            pres;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s1_r   <= '0;
            s2_r   <= '0;
            sp_r   <= '0;
            sid1_r <= '0;
            sid2_r <= '0;
        end
        else
        begin
            s1_r   <= {s1_r[0], chain_input_ch1};
            s2_r   <= {s2_r[0], chain_input_ch2};
            sp_r   <= {sp_r[0], tag_present};
            sid1_r <= tag_id;
            sid2_r <= sid1_r;
        end
    end

    assign in1  = s1_r[1];
    assign in2  = s2_r[1];
    assign pres = sp_r[1];

    // ****************************************************************
    // Pairing memory and teach sequencer
    // ****************************************************************
    // Pairing, history and budget model non-volatile storage: rst is the
    // power-on reset and is the moment a ready teach is committed.
    localparam int HW = $clog2(HIST + 1);

    atc_state_t            st_r;
    atc_state_t            st_nxt;
    logic [TMR_W-1:0]      tmr_r;
    logic [TMR_W-1:0]      tmr_nxt;
    // Declared values are the factory state of the non-volatile store.
    logic [ID_W-1:0]       cand_r = '0;
    logic [ID_W-1:0]       cand_nxt;
    logic [ID_W-1:0]       pair_r = '0;
    logic [ID_W-1:0]       pair_nxt;
    logic                  pv_r = 1'b0;
    logic                  pv_nxt;
    logic [BUDGET_W-1:0]   bud_r = BUDGET_RESET;
    logic [BUDGET_W-1:0]   bud_nxt;
    logic [ID_W-1:0]       hist_r [HIST] = '{default: '0};
    logic [ID_W-1:0]       hist_nxt [HIST];
    logic [HW-1:0]         hcnt_r = '0;
    logic [HW-1:0]         hcnt_nxt;
    logic                  power_up_r = 1'b1;
    logic                  seen;

    function automatic logic in_history(input logic [ID_W-1:0] id);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < HIST; i++)
        begin
            if (HW'(i) < hcnt_r && hist_r[i] == id)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    assign seen = in_history(sid2_r);

    always_comb
    begin
        st_nxt   = st_r;
        tmr_nxt  = tmr_r;
        cand_nxt = cand_r;
        pair_nxt = pair_r;
        pv_nxt   = pv_r;
        bud_nxt  = bud_r;
        hcnt_nxt = hcnt_r;
        for (int i = 0; i < HIST; i++)
        begin
            hist_nxt[i] = hist_r[i];
        end
        if (rst)
        begin
            st_nxt  = ATC_IDLE;
            tmr_nxt = '0;
            if (st_r == ATC_READY && !power_up_r)
            begin
                pair_nxt         = cand_r;
                bud_nxt          = bud_r - BUDGET_STEP;
                hist_nxt[hcnt_r] = cand_r;
                hcnt_nxt         = hcnt_r + HW'(1);
            end
        end
        else
        case (st_r)
            ATC_IDLE:
            begin
                if (pres && !pv_r)
                begin
                    pair_nxt          = sid2_r;
                    pv_nxt            = 1'b1;
                    hist_nxt[hcnt_r]  = sid2_r;
                    hcnt_nxt          = hcnt_r + HW'(1);
                end
                else if (pres && sid2_r != pair_r && !seen
                         && bud_r != '0)
                begin
                    cand_nxt = sid2_r;
                    tmr_nxt  = '0;
                    st_nxt   = ATC_LEARN;
                end
            end
            ATC_LEARN:
            begin
                if (!pres || sid2_r != cand_r)
                begin
                    st_nxt = ATC_IDLE;
                end
                else if (tmr_r >= TMR_W'(TEACH_T - 1))
                begin
                    tmr_nxt = '0;
                    st_nxt  = ATC_READY;
                end
                else
                begin
                    tmr_nxt = tmr_r + TMR_W'(1);
                end
            end
            ATC_READY:
            begin
                if (!pres || sid2_r != cand_r)
                begin
                    st_nxt = ATC_IDLE;
                end
                else if (tmr_r >= TMR_W'(COMMIT_T - 1))
                begin
                    st_nxt = ATC_EXPIRED;
                end
                else
                begin
                    tmr_nxt = tmr_r + TMR_W'(1);
                end
            end
            default:
            begin
                if (!pres || sid2_r != cand_r)
                begin
                    st_nxt = ATC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        power_up_r <= rst;
        st_r       <= st_nxt;
        tmr_r      <= tmr_nxt;
        cand_r     <= cand_nxt;
        pair_r     <= pair_nxt;
        pv_r       <= pv_nxt;
        bud_r      <= bud_nxt;
        hcnt_r     <= hcnt_nxt;
        for (int i = 0; i < HIST; i++)
        begin
            hist_r[i] <= hist_nxt[i];
        end
    end

    // ****************************************************************
    // Safety outputs and indicators
    // ****************************************************************
    logic     out_r;
    logic     out_nxt;
    logic     inled_r;
    logic     inled_nxt;
    logic     dev_r;
    atc_ind_t ind;

    always_comb
    begin
        out_nxt   = pres && pv_r && sid2_r == pair_r
                    && in1 && in2;
        inled_nxt = in1 && in2;
        case (st_r)
            ATC_LEARN: ind = ATC_IND_NORMAL;
            ATC_READY: ind = ATC_IND_QUICK;
            default:   ind = ATC_IND_STEADY;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            out_r   <= 1'b0;
            inled_r <= 1'b0;
            dev_r   <= 1'b0;
        end
        else
        begin
            out_r   <= out_nxt;
            inled_r <= inled_nxt;
            dev_r   <= 1'b1;
        end
    end

    atc_blinker #(
        .NORM_ON   (NORM_ON),
        .NORM_PER  (NORM_PER),
        .QUICK_ON  (QUICK_ON),
        .QUICK_PER (QUICK_PER)
    ) u_blink (
        .clock     (clock),
        .rst       (rst),
        .mode      (ind),
        .steady_on (pres && sid2_r == pair_r && pv_r),
        .lamp      (gate_led)
    );

    assign safe_out_ch1       = out_r;
    assign safe_out_ch2       = out_r;
    assign signal_diag_output = out_r;
    assign input_led          = inled_r;
    assign device_led         = dev_r;
    assign budget_left        = bud_r;
    assign paired_valid       = pv_r;

endmodule

// ---- verif/atc_eval_model.sv ----
`timescale 1ns/1ps
module atc_eval_model
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic closed,
    input  wire logic in_ch1,
    input  wire logic in_ch2,
    output logic      up_ch1 = 1'b1,
    output logic      up_ch2 = 1'b1,
    output logic      disagree
);
    // The upstream switch moves both channels together, off the falling edge.
    always @(negedge clock)
    begin
        up_ch1 <= closed;
        up_ch2 <= closed;
    end

    // The evaluator latches any cycle in which the two channels differ.
    always @(posedge clock)
    begin
        if (rst)
            disagree <= 1'b0;
        else if (in_ch1 !== in_ch2)
            disagree <= 1'b1;
    end
endmodule

// ---- verif/atc_switch_asserts.sv ----
`timescale 1ns/1ps
module atc_switch_asserts
(
    input wire logic                     clock,
    input wire logic                     rst,
    input wire logic                     tag_present,
    input wire logic [atc_pkg::ID_W-1:0] tag_id,
    input wire logic                     chain_input_ch1,
    input wire logic                     chain_input_ch2,
    input wire logic                     safe_out_ch1,
    input wire logic                     safe_out_ch2,
    input wire logic                     signal_diag_output,
    input wire logic                     gate_led,
    input wire logic                     input_led,
    input wire logic                     device_led,
    input wire logic [atc_pkg::BUDGET_W-1:0] budget_left,
    input wire logic                     paired_valid
);
    import atc_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_chan_agree: assert property (safe_out_ch1 == safe_out_ch2)
        else $error("Safety channels differ.");
    a_out_needs_in: assert property (safe_out_ch1 |-> $past(chain_input_ch1, 3)
        && $past(chain_input_ch2, 3)) else $error("Output high without both inputs.");
    a_out_needs_tag: assert property (safe_out_ch1 |-> $past(tag_present, 3))
        else $error("Output high without actuator.");
    a_open_drops: assert property ((!chain_input_ch1 || !chain_input_ch2)
        |-> ##3 (!safe_out_ch1 && !safe_out_ch2)) else $error("Open gate kept outputs.");
    a_led_lit: assert property ((chain_input_ch1 && chain_input_ch2)
        |-> ##3 input_led) else $error("Input lamp dark with inputs high.");
    a_led_dark: assert property ((!chain_input_ch1 && !chain_input_ch2)
        |-> ##3 !input_led) else $error("Input lamp lit with inputs low.");
    a_budget_step: assert property ($changed(budget_left)
        |-> budget_left == $past(budget_left) - 4'h1) else $error("Budget step not one.");
    a_budget_by_pwr: assert property ($changed(budget_left) |-> $past(rst))
        else $error("Budget changed without power cycle.");
    a_budget_floor: assert property (budget_left == 4'h0 |=> budget_left == 4'h0)
        else $error("Spent budget recovered.");
    a_budget_cap: assert property (budget_left <= BUDGET_RESET)
        else $error("Budget above eight.");
endmodule

// ---- verif/actuator_teach_and_chain_tb.sv ----
`timescale 1ns/1ps
module actuator_teach_and_chain_tb;
    import atc_pkg::*;
    localparam int TT = 100;
    localparam int CT = 200;
    localparam logic [15:0] ID_A = 16'h0a11;
    localparam logic [15:0] ID_B = 16'h0b22;
    localparam logic [15:0] ID_C = 16'h0c33;
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic              tag_present = 1'b0;
    logic [ID_W-1:0]   tag_id = 16'h0000;
    logic              up_closed = 1'b1;
    logic              ch1, ch2, s1, s2, dg, gl, il, dl, pv, bad;
    logic [BUDGET_W-1:0] bl;
    logic [15:0]       rid;
    int                err_count = 0;
    int                checks = 0;
    int                cyc = 0;
    string             nq[$];
    logic [15:0]       eq[$];
    logic [15:0]       rq[$];

    atc_switch #(.TEACH_T(TT), .COMMIT_T(CT), .NORM_ON(5), .NORM_PER(10),
                 .QUICK_ON(1), .QUICK_PER(10)) dut_u
    (
        .clock(clock), .rst(rst), .tag_present(tag_present), .tag_id(tag_id),
        .chain_input_ch1(ch1), .chain_input_ch2(ch2), .safe_out_ch1(s1),
        .safe_out_ch2(s2), .signal_diag_output(dg), .gate_led(gl), .input_led(il),
        .device_led(dl), .budget_left(bl), .paired_valid(pv)
    );

    atc_eval_model eval_u
    (
        .clock(clock), .rst(rst), .closed(up_closed), .in_ch1(s1), .in_ch2(s2),
        .up_ch1(ch1), .up_ch2(ch2), .disagree(bad)
    );

    initial
    forever
        #5 clock = ~clock;

    task automatic stop_test;
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic note(string n, logic [15:0] e);
        nq.push_back(n);
        eq.push_back(e);
    endtask

    task automatic wait_n(int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic put(logic p, logic [15:0] id);
        @(negedge clock);
        tag_present = p;
        tag_id = id;
    endtask

    // One edge of reset stands for a supply interruption.
    task automatic pwr;
        @(negedge clock);
        rst = 1'b1;
        wait_n(1);
        rst = 1'b0;
        wait_n(6);
    endtask

    task automatic st_chk(string n, logic o, logic i, logic p, logic [3:0] b);
        note(n, {6'h00, o, o, o, 1'b1, i, p, b});
        rq.push_back({6'h00, s1, s2, dg, dl, il, pv, bl});
    endtask

    task automatic lamp(string n, int e);
        int k;
        k = 0;
        repeat (20)
        begin
            @(negedge clock);
            k += (gl === 1'b1) ? 1 : 0;
        end
        note(n, 16'(e));
        rq.push_back(16'(k));
    endtask

    initial
    forever
    begin
        wait (rq.size() > 0);
        check(nq.pop_front(), rq.pop_front(), eq.pop_front());
    end

    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            stop_test();
        end
    end

    initial
    begin
        void'($urandom(32'h3a50));
        wait_n(8);
        rst = 1'b0;
        wait_n(4);
        st_chk("reset", 0, 1, 0, 4'h8);
        put(1, ID_A);
        wait_n(6);
        st_chk("first pair", 1, 1, 1, 4'h8);
        lamp("steady", 20);
        up_closed = 1'b0;
        wait_n(6);
        st_chk("gate open", 0, 0, 1, 4'h8);
        up_closed = 1'b1;
        wait_n(6);
        st_chk("gate closed", 1, 1, 1, 4'h8);
        put(0, ~ID_A);
        wait_n(6);
        st_chk("tag gone", 0, 1, 1, 4'h8);
        put(1, ID_B);
        wait_n(4);
        lamp("normal", 10);
        wait_n(TT);
        lamp("quick", 2);
        pwr();
        st_chk("commit", 1, 1, 1, 4'h7);
        put(0, ~ID_B);
        wait_n(2);
        put(1, ID_C);
        wait_n(30);
        put(0, ~ID_C);
        wait_n(4);
        lamp("abort lamp", 0);
        put(1, ID_B);
        wait_n(6);
        st_chk("abort", 1, 1, 1, 4'h7);
        put(0, ~ID_B);
        wait_n(2);
        put(1, ID_A);
        wait_n(TT + 10);
        lamp("old id", 0);
        pwr();
        st_chk("old refused", 0, 1, 1, 4'h7);
        put(0, ~ID_A);
        wait_n(2);
        put(1, ID_C);
        wait_n(TT + CT + 20);
        pwr();
        st_chk("late cycle", 0, 1, 1, 4'h7);
        for (int i = 1; i <= 8; i++)
        begin
            rid = {4'(i), 12'($urandom)};
            put(0, ~rid);
            wait_n(2);
            put(1, rid);
            wait_n(TT + 10);
            pwr();
            st_chk("relearn", 1'(i < 8), 1, 1, 4'(i < 8 ? 7 - i : 0));
        end
        note("agree", 16'h0000);
        rq.push_back({15'h0000, bad});
        wait (rq.size() == 0);
        wait_n(1);
        stop_test();
    end
endmodule

bind atc_switch atc_switch_asserts chk_u
(
    .clock(clock), .rst(rst), .tag_present(tag_present), .tag_id(tag_id),
    .chain_input_ch1(chain_input_ch1), .chain_input_ch2(chain_input_ch2),
    .safe_out_ch1(safe_out_ch1), .safe_out_ch2(safe_out_ch2),
    .signal_diag_output(signal_diag_output), .gate_led(gate_led),
    .input_led(input_led), .device_led(device_led), .budget_left(budget_left),
    .paired_valid(paired_valid)
);
